/* File: adc_conversion_sequencer.sv */
`timescale 1ns/100ps
`include "adc_seq_consts.svh"
// Operation
// - Four selectable conversion start sources
// - Busy bit reads one while converting
// - Busy falling edge at the end of a series sets done, interrupt
// - Result valid whenever done flag set
// - Timer width picks low/high overflow
// - Powered when enabled or bursting
// - Burst powers up, converts, shuts down
// - Pre-tracking: convert immediately on start, except under burst
// - Post-tracking: hardware track, then convert
// - Post-tracking: input disconnected after conversion
// - Dual-tracking: track after, and between
// - Multiplexer routes 27 ground-referenced inputs
// - Hardware track lasts setting plus two
// - Conversion is 13 SAR plus 2
// - Burst start launches repeat count conversions
module adc_conversion_sequencer (
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire logic [3:0]                  regAddr,
    input  wire logic [7:0]                  regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic [7:0]                       regRdata,
    input  wire adc_seq_pkg::timer_events_s  timerEvents,
    input  wire logic                        extConvertStart,
    input  wire logic [11:0]                 sarResult,
    output logic                             adcPowered,
    output logic                             sampleConnect,
    output logic                             sarConverting,
    output logic [4:0]                       muxSelect,
    output logic                             conversionIrq
);
    import adc_seq_pkg::*;

    // ==================================================================
    // Registers
    // ==================================================================
    logic [7:0]  control_reg;
    logic [7:0]  config_reg;
    logic [4:0]  channel_reg;
    logic [15:0] result_reg;
    logic [15:0] accum_reg;
    logic        busy_reg;
    logic        done_reg;
    logic        busyPrev_reg;
    seq_state_e  state_reg;
    logic [4:0]  count_reg;
    logic [4:0]  samples_reg;
    logic [2:0]  extSync_reg;
    logic        extLevel_reg;
    logic        startPulse;
    logic        sarTick;
    logic        swStart;
    logic        busyFall;

    start_src_e  startSource;
    track_mode_e trackMode;
    logic        burstOn;
    logic        enableBit;
    logic [3:0]  trackSetting;
    logic [1:0]  repeatSel;
    logic [1:0]  sarDivide;

    assign startSource  = start_src_e'(control_reg[`CTL_SRC_LSB +: 2]);
    assign trackMode    = track_mode_e'(control_reg[`CTL_TM_LSB +: 2]);
    assign burstOn      = control_reg[`CTL_BURST_BIT];
    assign enableBit    = control_reg[`CTL_ENABLE_BIT];
    assign trackSetting = config_reg[`CFG_TK_LSB +: 4];
    assign repeatSel    = config_reg[`CFG_RPT_LSB +: 2];
    assign sarDivide    = config_reg[`CFG_DIV_LSB +: 2];

    // Number of samples per burst or accumulation: 1, 4, 8 or 16.
    function automatic logic [4:0] repeat_count(input logic [1:0] sel);
        case (sel)
            2'h0:    repeat_count = 5'h01;
            2'h1:    repeat_count = 5'h04;
            2'h2:    repeat_count = 5'h08;
            default: repeat_count = 5'h10;
        endcase
    endfunction : repeat_count

    // ==================================================================
    // Start event selection
    // ==================================================================
    // The pin passes three flops; an edge counts when the last two agree.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            extSync_reg  <= 3'h0;
            extLevel_reg <= 1'b0;
        end else begin
            extSync_reg <= {extSync_reg[1:0], extConvertStart};
            if (extSync_reg[1] == extSync_reg[2]) begin
                extLevel_reg <= extSync_reg[2];
            end
        end
    end

    assign swStart = regWr && regAddr == `OFS_CONTROL
                     && regWdata[`CTL_BUSY_BIT];

    always_comb begin
        case (startSource)
            SRC_SOFTWARE: startPulse = swStart;
            SRC_TIMER3:   startPulse = timerEvents.timer3Split
                                       ? timerEvents.timer3Low
                                       : timerEvents.timer3High;
            SRC_EXTPIN:   startPulse = extSync_reg[1] && extSync_reg[2]
                                       && !extLevel_reg;
            default:      startPulse = timerEvents.timer2Split
                                       ? timerEvents.timer2Low
                                       : timerEvents.timer2High;
        endcase
    end

    // ==================================================================
    // Sequencer
    // ==================================================================
    sar_clock_divider #(
        .DIV_W (2)
    ) sar_clock_divider_inst (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .run     (state_reg == ST_CONV),
        .divide  (sarDivide),
        .sarTick (sarTick)
    );

    // Pre-tracking under burst is a software fault; treated as post.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_reg   <= ST_IDLE;
            count_reg   <= 5'h00;
            samples_reg <= 5'h00;
            busy_reg    <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (startPulse && (enableBit || burstOn)) begin
                        busy_reg    <= 1'b1;
                        samples_reg <= 5'h00;
                        count_reg   <= 5'h00;
                        if (trackMode == TM_PRE && !burstOn) begin
                            state_reg <= ST_WRAP;
                        end else begin
                            state_reg <= ST_TRACK;
                        end
                    end
                end
                ST_TRACK: begin
                    if (count_reg == 5'(trackSetting)
                        + 5'(`TRACK_EXTRA) - 5'h01) begin
                        count_reg <= 5'h00;
                        state_reg <= ST_WRAP;
                    end else begin
                        count_reg <= count_reg + 5'h01;
                    end
                end
                ST_WRAP: begin
                    // First of the two edge cycles of a conversion.
                    state_reg <= ST_CONV;
                    count_reg <= 5'h00;
                end
                ST_CONV: begin
                    if (sarTick) begin
                        if (count_reg == 5'(`CONV_SAR_CYCLES) - 5'h01) begin
                            state_reg   <= ST_DONE;
                            samples_reg <= samples_reg + 5'h01;
                        end
                        count_reg <= count_reg + 5'h01;
                    end
                end
                default: begin
                    count_reg <= 5'h00;
                    if (samples_reg < repeat_count(repeatSel)
                        && burstOn) begin
                        state_reg <= ST_TRACK;
                    end else if (samples_reg < repeat_count(repeatSel)) begin
                        // Non-burst accumulation waits for its next start.
                        busy_reg  <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else begin
                        busy_reg    <= 1'b0;
                        samples_reg <= 5'h00;
                        state_reg   <= ST_IDLE;
                    end
                end
            endcase
            // Starts outside idle are ignored by construction.
        end
    end

    // ==================================================================
    // Result and done flag
    // ==================================================================
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            accum_reg  <= 16'h0000;
            result_reg <= 16'h0000;
        end else if (state_reg == ST_DONE) begin
            if (samples_reg >= repeat_count(repeatSel)) begin
                result_reg <= accum_reg + {4'h0, sarResult};
                accum_reg  <= 16'h0000;
            end else begin
                accum_reg  <= accum_reg + {4'h0, sarResult};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            busyPrev_reg <= 1'b0;
        end else begin
            busyPrev_reg <= busy_reg;
        end
    end

    // Done is only set once the final sample of a series lands.
    assign busyFall = busyPrev_reg && !busy_reg && samples_reg == 5'h00;

    // Set wins over a software clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            done_reg <= 1'b0;
        end else if (busyFall) begin
            done_reg <= 1'b1;
        end else if (regWr && regAddr == `OFS_CONTROL
                     && !regWdata[`CTL_DONE_BIT]) begin
            done_reg <= 1'b0;
        end
    end

    // ==================================================================
    // Register port
    // ==================================================================
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            control_reg <= `CONTROL_RESET;
            config_reg  <= `CONFIG_RESET;
            channel_reg <= `CHANNEL_RESET;
        end else if (regWr) begin
            if (regAddr == `OFS_CONTROL) begin
                control_reg <= regWdata;
            end else if (regAddr == `OFS_CONFIG) begin
                config_reg <= regWdata;
            end else if (regAddr == `OFS_CHANNEL) begin
                if (regWdata[4:0] < `CHANNEL_COUNT) begin
                    channel_reg <= regWdata[4:0];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            if (regAddr == `OFS_CONTROL) begin
                regRdata <= {control_reg[7:4], done_reg, busy_reg,
                             control_reg[1:0]};
            end else if (regAddr == `OFS_CONFIG) begin
                regRdata <= config_reg;
            end else if (regAddr == `OFS_CHANNEL) begin
                regRdata <= {3'h0, channel_reg};
            end else if (regAddr == `OFS_RESULT_LOW) begin
                regRdata <= result_reg[7:0];
            end else if (regAddr == `OFS_RESULT_HIGH) begin
                regRdata <= result_reg[15:8];
            end else if (regAddr == `OFS_STATUS) begin
                regRdata <= {3'h0, state_reg};
            end else begin
                regRdata <= 8'h00;
            end
        end else begin
            regRdata <= 8'h00;
        end
    end

    // ==================================================================
    // Analog controls
    // ==================================================================
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            adcPowered    <= 1'b0;
            sampleConnect <= 1'b0;
            sarConverting <= 1'b0;
            muxSelect     <= `CHANNEL_RESET;
            conversionIrq <= 1'b0;
        end else begin
            adcPowered <= enableBit || state_reg != ST_IDLE;
            if (state_reg == ST_TRACK) begin
                sampleConnect <= 1'b1;
            end else if (state_reg == ST_IDLE) begin
                sampleConnect <= enableBit && trackMode != TM_POST;
            end else begin
                sampleConnect <= 1'b0;
            end
            sarConverting <= state_reg == ST_CONV;
            muxSelect     <= channel_reg;
            conversionIrq <= done_reg && control_reg[`CTL_IRQEN_BIT];
        end
    end

    // ==================================================================
    // Checks
    // ==================================================================
    a_busy_on_start: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_reg == ST_IDLE && startPulse && enableBit |=> busy_reg)
        else $error("Busy not set after start");
    a_done_after_fall: assert property (@(posedge ref_clk)
        disable iff (!resetn) busyFall |=> done_reg)
        else $error("Done flag missed falling busy");
    a_pre_immediate: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_reg == ST_IDLE && startPulse && enableBit && !burstOn
        && trackMode == TM_PRE |=> state_reg == ST_WRAP)
        else $error("Pre-tracking did not convert at once");
    a_track_length: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(state_reg == ST_TRACK) && trackSetting == 4'h2
        |-> ##4 state_reg == ST_WRAP)
        else $error("Tracking length wrong");
    a_wrap_to_conv: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_reg == ST_WRAP |=> state_reg == ST_CONV)
        else $error("Conversion did not follow edge cycle");
    a_conv_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(state_reg == ST_CONV) && sarDivide == 2'h0
        |-> ##13 state_reg == ST_DONE)
        else $error("Conversion length wrong");
    a_start_ignored: assert property (@(posedge ref_clk)
        disable iff (!resetn) state_reg == ST_TRACK && startPulse
        |=> state_reg == ST_WRAP || count_reg != 5'h00)
        else $error("Start disturbed tracking");
    a_power_state: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_reg != ST_IDLE |=> adcPowered)
        else $error("Converter unpowered while active");
    a_post_release: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_reg == ST_IDLE && trackMode == TM_POST |=> !sampleConnect)
        else $error("Post-tracking input connected while idle");

    c_soft_start: cover property (@(posedge ref_clk)
        startSource == SRC_SOFTWARE && swStart && state_reg == ST_IDLE);
    c_burst_done: cover property (@(posedge ref_clk) burstOn && busyFall);
    c_pin_start: cover property (@(posedge ref_clk)
        startSource == SRC_EXTPIN && startPulse);
endmodule : adc_conversion_sequencer

/* File: adc_seq_consts.svh */
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
// Register offsets on the plain register port.
`define OFS_CONTROL      4'h0
`define OFS_CONFIG       4'h1
`define OFS_CHANNEL      4'h2
`define OFS_RESULT_LOW   4'h3
`define OFS_RESULT_HIGH  4'h4
`define OFS_STATUS       4'h5
// Control register fields.
`define CTL_SRC_LSB      0
`define CTL_BUSY_BIT     2
`define CTL_DONE_BIT     3
`define CTL_BURST_BIT    4
`define CTL_IRQEN_BIT    5
`define CTL_TM_LSB       6
`define CTL_ENABLE_BIT   7
// Config register fields.
`define CFG_TK_LSB       0
`define CFG_RPT_LSB      4
`define CFG_DIV_LSB      6
// Reset values.
`define CONTROL_RESET    8'h00
`define CONFIG_RESET     8'h00
`define CHANNEL_RESET    5'h1F
// Timing in converter subsystem clock cycles and divided clock cycles.
`define CONV_SAR_CYCLES  4'hD
`define CONV_EDGE_CYCLES 2'h2
`define TRACK_EXTRA      2'h2
`define CHANNEL_COUNT    5'h1B
`endif

/* File: adc_seq_pkg.sv */
package adc_seq_pkg;
    typedef enum logic [1:0] {
        SRC_SOFTWARE = 2'h0,
        SRC_TIMER3   = 2'h1,
        SRC_EXTPIN   = 2'h2,
        SRC_TIMER2   = 2'h3
    } start_src_e;
    typedef enum logic [1:0] {
        TM_RESERVED = 2'h0,
        TM_POST     = 2'h1,
        TM_PRE      = 2'h2,
        TM_DUAL     = 2'h3
    } track_mode_e;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_TRACK = 5'b00010,
        ST_CONV  = 5'b00100,
        ST_WRAP  = 5'b01000,
        ST_DONE  = 5'b10000
    } seq_state_e;
    typedef struct packed {
        logic       timer2Low;
        logic       timer2High;
        logic       timer3Low;
        logic       timer3High;
        logic       timer2Split;
        logic       timer3Split;
    } timer_events_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;
endpackage : adc_seq_pkg

/* File: sar_clock_divider.sv */
`timescale 1ns/100ps
// Produces one-cycle enables at the SAR clock rate while running.
module sar_clock_divider #(
    parameter int DIV_W = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divide,
    output logic                  sarTick
);
    logic [DIV_W-1:0] count_reg;

    // The tick is combinational so that the first SAR period begins with
    // the conversion state; a registered tick would add one cycle.
    assign sarTick = run && count_reg >= divide;

    always_ff @(posedge ref_clk) begin
        if (!resetn || !run || sarTick) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    a_tick_spacing: assert property (@(posedge ref_clk)
        disable iff (!resetn) sarTick && divide != '0 |=> !sarTick)
        else $error("SAR tick repeated with nonzero divide");
endmodule : sar_clock_divider

/* File: sar_far_side_model.sv */
`timescale 1ns/100ps
// =====================================================================
// Far side of the sequencer: timers, start pin and analog SAR core.
// =====================================================================
module sar_far_side_model (
    input  wire logic                   ref_clk,
    input  wire logic                   adcPowered,
    output adc_seq_pkg::timer_events_s  timerEvents,
    output logic                        extConvertStart,
    output logic [11:0]                 sarResult
);
    import adc_seq_pkg::*;
    logic [11:0] code;

    initial begin
        timerEvents     = '0;
        extConvertStart = 1'b0;
        code            = 12'h5A3;
    end

    // An unpowered core shows no stable code, so the inverse is shown.
    assign sarResult = adcPowered ? code : ~code;

    task set_split(input logic t2Split, input logic t3Split);
        @(posedge ref_clk);
        timerEvents.timer2Split <= t2Split;
        timerEvents.timer3Split <= t3Split;
    endtask : set_split

    // Overflows are one-cycle pulses, as a real timer gives them.
    task pulse_overflow(input logic timer3, input logic high);
        @(posedge ref_clk);
        if (timer3) begin
            if (high) timerEvents.timer3High <= 1'b1;
            else timerEvents.timer3Low <= 1'b1;
        end else begin
            if (high) timerEvents.timer2High <= 1'b1;
            else timerEvents.timer2Low <= 1'b1;
        end
        @(posedge ref_clk);
        timerEvents.timer2Low  <= 1'b0;
        timerEvents.timer2High <= 1'b0;
        timerEvents.timer3Low  <= 1'b0;
        timerEvents.timer3High <= 1'b0;
    endtask : pulse_overflow

    // The pin is slow, so it is held long enough to pass the synchroniser.
    task pin_rise;
        @(posedge ref_clk);
        extConvertStart <= 1'b1;
        repeat (8) @(posedge ref_clk);
        extConvertStart <= 1'b0;
    endtask : pin_rise
endmodule : sar_far_side_model

/* File: adc_conversion_sequencer_test.sv */
`timescale 1ns/100ps
`include "adc_seq_consts.svh"
module adc_conversion_sequencer_test;
    import adc_seq_pkg::*;
    logic          ref_clk;
    logic          resetn;
    logic [3:0]    regAddr;
    logic [7:0]    regWdata;
    logic          regWr;
    logic          regRd;
    logic [7:0]    regRdata;
    timer_events_s timerEvents;
    logic          extConvertStart;
    logic [11:0]   sarResult;
    logic          adcPowered;
    logic          sampleConnect;
    logic          sarConverting;
    logic [4:0]    muxSelect;
    logic          conversionIrq;
    int            num_errors;
    int            total_checks;
    int            convCount;
    int            convLen;
    int            lastConvLen;
    int            trackLen;
    int            lastTrackLen;
    logic          prevConv;
    logic          prevTrack;
    logic [7:0]    rd;
    logic [7:0]    rdHigh;

    adc_conversion_sequencer adc_conversion_sequencer_inst (
        .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .timerEvents(timerEvents),
        .extConvertStart(extConvertStart), .sarResult(sarResult),
        .adcPowered(adcPowered), .sampleConnect(sampleConnect),
        .sarConverting(sarConverting), .muxSelect(muxSelect),
        .conversionIrq(conversionIrq)
    );
    sar_far_side_model sar_far_side_model_inst (
        .ref_clk(ref_clk), .adcPowered(adcPowered),
        .timerEvents(timerEvents), .extConvertStart(extConvertStart),
        .sarResult(sarResult)
    );

    // =================================================================
    // Clock, watchdog and activity monitor
    // =================================================================
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        #(25 * 40000);
        num_errors++;
        wrap_up;
    end
    always @(posedge ref_clk) begin
        prevConv  <= sarConverting;
        prevTrack <= sampleConnect;
        if (sarConverting === 1'b1 && prevConv !== 1'b1) convCount <= convCount + 1;
        convLen  <= (sarConverting === 1'b1) ? convLen + 1 : 0;
        trackLen <= (sampleConnect === 1'b1) ? trackLen + 1 : 0;
        if (sarConverting !== 1'b1 && prevConv === 1'b1) lastConvLen <= convLen;
        if (sampleConnect !== 1'b1 && prevTrack === 1'b1) lastTrackLen <= trackLen;
    end

    // =================================================================
    // Bus cycles and comparison
    // =================================================================
    task reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : reg_read
    task check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val
    task wait_done;
        int n;
        n  = 0;
        rd = 8'h00;
        while (rd[`CTL_DONE_BIT] !== 1'b1 && n < 300) begin
            reg_read(`OFS_CONTROL, rd);
            n++;
        end
        check_val(rd[`CTL_DONE_BIT], 1'b1, "done flag");
    endtask : wait_done
    task wrap_up;
        if (num_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    // =================================================================
    // Scenarios
    // =================================================================
    task t_reset_values;
        reg_read(`OFS_CONTROL, rd);
        check_val(rd, `CONTROL_RESET, "control reset");
        reg_read(`OFS_CONFIG, rd);
        check_val(rd, `CONFIG_RESET, "config reset");
        reg_read(`OFS_CHANNEL, rd);
        check_val(rd, {3'h0, `CHANNEL_RESET}, "channel reset");
        reg_read(4'hF, rd);
        check_val(rd, 8'h00, "unmapped read");
        reg_read(`OFS_STATUS, rd);
        check_val(rd, {3'h0, ST_IDLE}, "idle status");
        check_val(muxSelect, `CHANNEL_RESET, "mux reset");
    endtask : t_reset_values
    task t_shutdown;
        int n;
        n = convCount;
        reg_write(`OFS_CONTROL, 8'h04);
        repeat (30) @(posedge ref_clk);
        check_val(convCount, n, "start while shut down");
        check_val(adcPowered, 1'b0, "shutdown power");
        reg_write(`OFS_CONTROL, 8'h80);
        @(posedge ref_clk);
        #1 check_val(adcPowered, 1'b1, "enabled power");
    endtask : t_shutdown
    task t_software_pre;
        int n;
        reg_write(`OFS_CONFIG, 8'h00);
        repeat (20) @(posedge ref_clk);
        n = convCount;
        reg_write(`OFS_CONTROL, 8'hA4);
        reg_read(`OFS_CONTROL, rd);
        check_val(rd[`CTL_BUSY_BIT], 1'b1, "busy while converting");
        wait_done;
        check_val(convCount, n + 1, "one conversion");
        check_val(lastConvLen, `CONV_SAR_CYCLES, "conversion length");
        check_val(rd[`CTL_BUSY_BIT], 1'b0, "busy after end");
        check_val(conversionIrq, 1'b1, "irq raised");
        check_val(sampleConnect, 1'b1, "tracking between");
        reg_read(`OFS_RESULT_LOW, rd);
        reg_read(`OFS_RESULT_HIGH, rdHigh);
        check_val({rdHigh, rd}, 16'h05A3, "result");
        reg_write(`OFS_CONTROL, 8'hA0);
        @(posedge ref_clk);
        #1 check_val(conversionIrq, 1'b0, "irq cleared");
    endtask : t_software_pre
    task t_post_burst;
        int n;
        reg_write(`OFS_CONFIG, 8'h13);
        reg_write(`OFS_CONTROL, 8'h50);
        n = convCount;
        reg_write(`OFS_CONTROL, 8'h54);
        wait_done;
        check_val(convCount, n + 4, "burst count");
        check_val(lastTrackLen, 16'h0005, "track length");
        check_val(sampleConnect, 1'b0, "disconnected after");
        check_val(adcPowered, 1'b0, "burst shutdown");
        reg_read(`OFS_RESULT_LOW, rd);
        reg_read(`OFS_RESULT_HIGH, rdHigh);
        check_val({rdHigh, rd}, 16'h168C, "accumulated result");
    endtask : t_post_burst
    task t_dual_ignore;
        int n;
        reg_write(`OFS_CONFIG, 8'h42);
        n = convCount;
        reg_write(`OFS_CONTROL, 8'hC4);
        reg_write(`OFS_CONTROL, 8'hC4);
        wait_done;
        check_val(convCount, n + 1, "start ignored");
        check_val(lastConvLen, 2 * `CONV_SAR_CYCLES, "divided length");
        check_val(sampleConnect, 1'b1, "dual tracks after");
    endtask : t_dual_ignore
    task t_sources;
        int n;
        for (int i = 0; i < 5; i++) begin
            sar_far_side_model_inst.set_split(i[0], i[0]);
            if (i == 4) reg_write(`OFS_CONTROL, {6'h30, SRC_EXTPIN});
            else if (i < 2) reg_write(`OFS_CONTROL, {6'h30, SRC_TIMER3});
            else reg_write(`OFS_CONTROL, {6'h30, SRC_TIMER2});
            n = convCount;
            if (i < 4) begin
                sar_far_side_model_inst.pulse_overflow(i < 2, i[0]);
                repeat (10) @(posedge ref_clk);
                check_val(convCount, n, "unused overflow");
                sar_far_side_model_inst.pulse_overflow(i < 2, ~i[0]);
            end else sar_far_side_model_inst.pin_rise;
            wait_done;
            check_val(convCount, n + 1, "source start");
        end
    endtask : t_sources
    task t_channel;
        reg_write(`OFS_CHANNEL, 8'h1A);
        reg_write(`OFS_CHANNEL, 8'h1B);
        repeat (20) @(posedge ref_clk);
        reg_read(`OFS_CHANNEL, rd);
        check_val(rd, 8'h1A, "channel limit");
        check_val(muxSelect, 5'h1A, "mux select");
    endtask : t_channel

    initial begin
        resetn = 1'b0;
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        num_errors = 0;
        total_checks = 0;
        convCount = 0;
        convLen = 0;
        lastConvLen = 0;
        trackLen = 0;
        lastTrackLen = 0;
        prevConv = 1'b0;
        prevTrack = 1'b0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset_values;
        t_shutdown;
        t_software_pre;
        t_post_burst;
        t_dual_ignore;
        t_sources;
        t_channel;
        wrap_up;
    end
endmodule : adc_conversion_sequencer_test
